// >>> verilog/rop_pkg.sv
package rop_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ    = 125;
  localparam int unsigned PULSE_TIME_US   = 5;
  localparam int unsigned PULSE_CYCLES    = PULSE_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned BLANK_TIME_US   = 50;
  localparam int unsigned BLANK_CYCLES    = BLANK_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned OVL_TIME_US     = 1000;
  localparam int unsigned OVL_CYCLES      = OVL_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned GRADUAL_SHUTDOWN_CYCLES = 128;
  localparam int unsigned SYNC_STAGES     = 2;

  // ------------------------------------------------------------------
  // Sense input bit positions
  // ------------------------------------------------------------------
  localparam int unsigned SENSE_W      = 7;
  localparam int unsigned SNS_FREQ     = 0;
  localparam int unsigned SNS_HARD     = 1;
  localparam int unsigned SNS_SUP_ON   = 2;
  localparam int unsigned SNS_SUP_OFF  = 3;
  localparam int unsigned SNS_CSS_LOW  = 4;
  localparam int unsigned SNS_CSS_HIGH = 5;
  localparam int unsigned SNS_IDLE     = 6;
  localparam logic [6:0]  SENSE_RST    = 7'h00;

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_OFF      = 3'h0,
    ST_RUN      = 3'h1,
    ST_GRADUAL_SHUTDOWN = 3'h2,
    ST_HARDWAIT = 3'h3,
    ST_HALT     = 3'h4
  } rop_state_t;

  localparam rop_state_t STATE_RST = ST_OFF;

endpackage

// >>> verilog/rop_sense_if.sv
`timescale 1ns/10ps
interface rop_sense_if;
  logic [6:0] sense;

  modport sync_side (output sense);
  modport fsm_side  (input  sense);
endinterface

// >>> verilog/rop_sync.sv
`timescale 1ns/10ps
module rop_sync
#(
  parameter int unsigned WIDTH = rop_pkg::SENSE_W
)
(
  input  wire logic             clk,      // Logic clock
  input  wire logic             rst_b,    // Synchronous reset, low
  input  wire logic             clk_en,   // Freeze when low
  input  wire logic [WIDTH-1:0] raw,      // Asynchronous levels
  rop_sense_if.sync_side        sns       // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stab_q;
  logic [WIDTH-1:0] stab_d;

  if (WIDTH != rop_pkg::SENSE_W)
  begin : g_chk
    $error("rop_sync width must match the sense vector");
  end

  // ------------------------------------------------------------------
  // Two-stage chain, first stage feeds only the second
  // ------------------------------------------------------------------
  always_comb
  begin
    meta_d = raw;
    stab_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_q <= rop_pkg::SENSE_RST;
      stab_q <= rop_pkg::SENSE_RST;
    end
    else if (clk_en)
    begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign sns.sense = stab_q;

endmodule

// >>> verilog/rop_ocp_fsm.sv
// Summary of operation
// - Frequency-shift trip closes the soft-start discharge switch for 5 us.
// - Switch releases after the pulse; each new crossing after it gives a new pulse.
// - Overloads shorter than the overload time limit cause nothing more.
// - Overload limit expiry enters gradual shutdown, discharge held on.
// - Gradual shutdown runs exactly 128 switching cycles, then stops.
// - After gradual shutdown stay off until supply drops below off level.
// - Each restart after a protection stop begins with a full soft-start.
// - Hard-stop trip finishes the cycle, stops, holds discharge on.
// - After hard stop stay off until supply drops then returns to on.
// - Hard-stop comparator ignored while soft-start cap at or below 0.3 V.
// - Bootstrap charging element follows the low-side gate drive.
// - Both gate outputs held low before start-up.
// - Discharge blocked during start-up until soft-start cap reaches 1.85 V.
// - Discharge blocked about 50 us after leaving burst-mode idle.
`timescale 1ns/10ps
module rop_ocp_fsm
#(
  parameter int unsigned OVL_CYCLES   = rop_pkg::OVL_CYCLES,
  parameter int unsigned BLANK_CYCLES = rop_pkg::BLANK_CYCLES,
  parameter int unsigned OVL_W        = 32,
  parameter int unsigned BLANK_W      = 16
)
(
  input  wire logic clk,                 // 125 MHz logic clock
  input  wire logic rst_b,               // Synchronous reset, low
  input  wire logic clk_en,              // Freeze all state when low
  input  wire logic freq_shift_trip,     // Sense above freq_shift_threshold
  input  wire logic hard_stop_trip,      // Sense above hard_stop_threshold
  input  wire logic supply_on_reached,   // Supply at supply_on_threshold
  input  wire logic supply_below_off,    // Supply under supply_off_threshold
  input  wire logic css_above_low,       // Soft-start cap above 0.3 V
  input  wire logic css_above_start,     // Soft-start cap above 1.85 V
  input  wire logic burst_idle,          // Half-bridge in burst idle
  input  wire logic cycle_end,           // One-cycle pulse per switch cycle
  input  wire logic high_side_req,       // Oscillator high-side request
  input  wire logic low_side_req,        // Oscillator low-side request
  output logic      high_side_gate,      // High-side gate drive
  output logic      low_side_gate,       // Low-side gate drive
  output logic      bootstrap_charge_en, // Bootstrap charging element on
  output logic      css_discharge,       // Soft-start discharge switch on
  output logic      soft_start_go,       // Pulse: begin fresh soft-start
  output logic      switching_on,        // Half-bridge allowed to switch
  output logic      fault_halt           // Stopped by a protection
);

  localparam int unsigned PW = 10;
  localparam int unsigned SW = 8;

  if (rop_pkg::PULSE_CYCLES >= (1 << PW) || OVL_CYCLES < 2 ||
      OVL_W > 32 || BLANK_W > 32 ||
      OVL_CYCLES >= 64'(1) << OVL_W ||
      BLANK_CYCLES >= 64'(1) << BLANK_W || BLANK_CYCLES < 1)
  begin : g_chk
    $error("rop_ocp_fsm counter widths cannot hold the counts");
  end

  rop_sense_if sns ();

  rop_sync u_sync
  (
    .clk    (clk),
    .rst_b  (rst_b),
    .clk_en (clk_en),
    .raw    ({burst_idle, css_above_start, css_above_low,
              supply_below_off, supply_on_reached, hard_stop_trip,
              freq_shift_trip}),
    .sns    (sns.sync_side)
  );

  logic fs_s;
  logic hard_s;
  logic sup_on_s;
  logic sup_off_s;
  logic css_low_s;
  logic css_start_s;
  logic idle_s;

  assign fs_s        = sns.sense[rop_pkg::SNS_FREQ];
  assign hard_s      = sns.sense[rop_pkg::SNS_HARD];
  assign sup_on_s    = sns.sense[rop_pkg::SNS_SUP_ON];
  assign sup_off_s   = sns.sense[rop_pkg::SNS_SUP_OFF];
  assign css_low_s   = sns.sense[rop_pkg::SNS_CSS_LOW];
  assign css_start_s = sns.sense[rop_pkg::SNS_CSS_HIGH];
  assign idle_s      = sns.sense[rop_pkg::SNS_IDLE];

  function automatic logic sw_state(input rop_pkg::rop_state_t s);
    sw_state = (s == rop_pkg::ST_RUN) || (s == rop_pkg::ST_GRADUAL_SHUTDOWN) ||
               (s == rop_pkg::ST_HARDWAIT);
  endfunction

  // ------------------------------------------------------------------
  // Sequencer and timers
  // ------------------------------------------------------------------
  rop_pkg::rop_state_t state_q;
  rop_pkg::rop_state_t state_d;
  logic [PW-1:0]       pulse_cnt_q;
  logic [PW-1:0]       pulse_cnt_d;
  logic [OVL_W-1:0]    ovl_cnt_q;
  logic [OVL_W-1:0]    ovl_cnt_d;
  logic [SW-1:0]       ss_cnt_q;
  logic [SW-1:0]       ss_cnt_d;
  logic [BLANK_W-1:0]  blank_cnt_q;
  logic [BLANK_W-1:0]  blank_cnt_d;
  logic                fs_prev_q;
  logic                idle_prev_q;
  logic                started_q;
  logic                started_d;
  logic                pulse_on;
  logic                pulse_go;
  logic                overload;
  logic                ovl_expire;
  logic                hard_hit;

  assign pulse_on   = (pulse_cnt_q != '0);
  // Start-up and burst-exit blanking avoid a discharge deadlock
  assign pulse_go   = (state_q == rop_pkg::ST_RUN) && fs_s && !fs_prev_q &&
                      !pulse_on && started_q &&
                      (blank_cnt_q == '0);
  assign overload   = fs_s || pulse_on;
  assign ovl_expire = overload &&
                      (ovl_cnt_q == OVL_W'(OVL_CYCLES - 1));
  assign hard_hit   = hard_s && css_low_s;

  always_comb
  begin
    state_d     = state_q;
    pulse_cnt_d = pulse_on ? pulse_cnt_q - PW'(1) : '0;
    ovl_cnt_d   = '0;
    ss_cnt_d    = ss_cnt_q;
    blank_cnt_d = (blank_cnt_q != '0) ? blank_cnt_q - BLANK_W'(1) : '0;
    started_d   = started_q;
    if (idle_prev_q && !idle_s)
      blank_cnt_d = BLANK_W'(BLANK_CYCLES);
    unique case (state_q)
      rop_pkg::ST_OFF:
      begin
        started_d = 1'b0;
        ss_cnt_d  = '0;
        if (sup_on_s)
          state_d = rop_pkg::ST_RUN;
      end
      rop_pkg::ST_RUN:
      begin
        if (css_start_s)
          started_d = 1'b1;
        if (pulse_go)
          pulse_cnt_d = PW'(rop_pkg::PULSE_CYCLES);
        // Timer clears as soon as the overload is gone
        if (overload)
          ovl_cnt_d = ovl_cnt_q + OVL_W'(1);
        if (hard_hit)
          state_d = rop_pkg::ST_HARDWAIT;
        else if (ovl_expire)
          state_d = rop_pkg::ST_GRADUAL_SHUTDOWN;
      end
      rop_pkg::ST_GRADUAL_SHUTDOWN:
      begin
        pulse_cnt_d = '0;
        if (cycle_end)
          ss_cnt_d = ss_cnt_q + SW'(1);
        if (hard_hit)
          state_d = rop_pkg::ST_HARDWAIT;
        else if (cycle_end &&
                 ss_cnt_q == SW'(rop_pkg::GRADUAL_SHUTDOWN_CYCLES - 1))
          state_d = rop_pkg::ST_HALT;
      end
      rop_pkg::ST_HARDWAIT:
      begin
        pulse_cnt_d = '0;
        if (cycle_end)
          state_d = rop_pkg::ST_HALT;
      end
      rop_pkg::ST_HALT:
      begin
        pulse_cnt_d = '0;
        if (sup_off_s)
          state_d = rop_pkg::ST_OFF;
      end
      default:
        state_d = rop_pkg::ST_HALT;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q     <= rop_pkg::STATE_RST;
      pulse_cnt_q <= '0;
      ovl_cnt_q   <= '0;
      ss_cnt_q    <= '0;
      blank_cnt_q <= '0;
      fs_prev_q   <= 1'b0;
      idle_prev_q <= 1'b0;
      started_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q     <= state_d;
      pulse_cnt_q <= pulse_cnt_d;
      ovl_cnt_q   <= ovl_cnt_d;
      ss_cnt_q    <= ss_cnt_d;
      blank_cnt_q <= blank_cnt_d;
      fs_prev_q   <= fs_s;
      idle_prev_q <= idle_s;
      started_q   <= started_d;
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  logic hs_d;
  logic ls_d;
  logic css_d;
  logic ssg_d;
  logic sw_d;
  logic halt_d;

  always_comb
  begin
    sw_d   = sw_state(state_d) && !idle_s;
    hs_d   = sw_d && high_side_req && !low_side_req;
    ls_d   = sw_d && low_side_req;
    // Cap held empty while off so every restart is a full soft-start
    css_d  = (pulse_cnt_d != '0) || !sw_state(state_d) ||
             (state_d == rop_pkg::ST_GRADUAL_SHUTDOWN) ||
             (state_d == rop_pkg::ST_HARDWAIT);
    ssg_d  = (state_q == rop_pkg::ST_OFF) &&
             (state_d == rop_pkg::ST_RUN);
    halt_d = (state_d == rop_pkg::ST_HALT);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      high_side_gate      <= 1'b0;
      low_side_gate       <= 1'b0;
      bootstrap_charge_en <= 1'b0;
      css_discharge       <= 1'b1;
      soft_start_go       <= 1'b0;
      switching_on        <= 1'b0;
      fault_halt          <= 1'b0;
    end
    else if (clk_en)
    begin
      high_side_gate      <= hs_d;
      low_side_gate       <= ls_d;
      bootstrap_charge_en <= ls_d;
      css_discharge       <= css_d;
      soft_start_go       <= ssg_d;
      switching_on        <= sw_d;
      fault_halt          <= halt_d;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence hard_trip_seq;
    clk_en && state_q == rop_pkg::ST_RUN && hard_s && css_low_s;
  endsequence

  sequence hard_finish_seq;
    state_q == rop_pkg::ST_HARDWAIT && css_discharge;
  endsequence

  pulse_start_a: assert property (clk_en && pulse_go |=>
    css_discharge && pulse_cnt_q == PW'(rop_pkg::PULSE_CYCLES))
    else $error("discharge pulse did not start");
  pulse_end_a: assert property (clk_en && state_q == rop_pkg::ST_RUN &&
    pulse_cnt_q == PW'(1) && !hard_hit && !ovl_expire
    |=> !pulse_on ##0 !css_discharge)
    else $error("discharge pulse did not end");
  ovl_clear_a: assert property (clk_en && state_q == rop_pkg::ST_RUN &&
    !overload |=> ovl_cnt_q == '0)
    else $error("overload timer kept running");
  ovl_expire_a: assert property (clk_en && state_q == rop_pkg::ST_RUN &&
    ovl_expire && !hard_hit |=> state_q == rop_pkg::ST_GRADUAL_SHUTDOWN
    ##0 css_discharge)
    else $error("overload expiry missed");
  gradual_shutdown_len_a: assert property (clk_en &&
    state_q == rop_pkg::ST_GRADUAL_SHUTDOWN && cycle_end && !hard_hit &&
    ss_cnt_q == SW'(rop_pkg::GRADUAL_SHUTDOWN_CYCLES - 1)
    |=> state_q == rop_pkg::ST_HALT ##1 !high_side_gate)
    else $error("gradual shutdown length wrong");
  halt_hold_a: assert property (state_q == rop_pkg::ST_HALT && !sup_off_s
    |=> state_q == rop_pkg::ST_HALT)
    else $error("left halt before supply dropped");
  restart_ss_a: assert property (clk_en && state_q == rop_pkg::ST_OFF &&
    sup_on_s |=> soft_start_go && state_q == rop_pkg::ST_RUN)
    else $error("restart without soft-start");
  hard_stop_a: assert property (hard_trip_seq |=> hard_finish_seq)
    else $error("hard stop not taken");
  hard_halt_a: assert property (state_q == rop_pkg::ST_HARDWAIT &&
    clk_en && cycle_end |=> state_q == rop_pkg::ST_HALT)
    else $error("hard stop did not halt");
  hard_blank_a: assert property (clk_en && state_q == rop_pkg::ST_RUN &&
    !css_low_s |=> state_q != rop_pkg::ST_HARDWAIT)
    else $error("hard stop during start-up blanking");
  boot_follow_a: assert property (bootstrap_charge_en == low_side_gate &&
    !(high_side_gate && low_side_gate))
    else $error("bootstrap out of step with low side");
  gates_off_a: assert property (state_q == rop_pkg::ST_OFF &&
    $past(state_q) == rop_pkg::ST_OFF |-> !high_side_gate &&
    !low_side_gate)
    else $error("gate driven before start-up");
  start_block_a: assert property (clk_en && state_q == rop_pkg::ST_RUN &&
    !started_q && !hard_hit && !ovl_expire
    |=> !css_discharge)
    else $error("discharge before start threshold");
  blank_block_a: assert property (clk_en && idle_prev_q && !idle_s
    |=> blank_cnt_q == BLANK_W'(BLANK_CYCLES) ##0 !pulse_go)
    else $error("discharge after burst exit");

endmodule

// >>> verif/rop_stage_model.sv
`timescale 1ns/10ps
module rop_stage_model
(
  input  wire logic clk,           // Logic clock
  input  wire logic rst_b,         // Synchronous reset, low
  input  wire logic osc_en,        // Bench lets the oscillator run
  input  wire logic switching_on,  // Block allows switching
  output logic      cycle_end,     // Pulse at each cycle end
  output logic      high_side_req, // First half of the cycle
  output logic      low_side_req   // Second half of the cycle
);
  logic [2:0] phase_q;

  // --------------------------------------------------------------
  // Oscillator, eight clocks a cycle
  // --------------------------------------------------------------
  // Stands still with both requests low whenever switching is off
  always_ff @(posedge clk)
  begin
    if (!rst_b || !(osc_en && switching_on))
    begin
      phase_q       <= 3'h0;
      cycle_end     <= 1'b0;
      high_side_req <= 1'b0;
      low_side_req  <= 1'b0;
    end
    else
    begin
      phase_q       <= phase_q + 3'h1;
      cycle_end     <= (phase_q == 3'h7);
      high_side_req <= (phase_q < 3'h3);
      low_side_req  <= (phase_q > 3'h3) && (phase_q < 3'h7);
    end
  end
endmodule

// >>> verif/resonant_overcurrent_protection_fsm_bench.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module resonant_overcurrent_protection_fsm_bench;
  // Overload limit kept above one pulse so a lone pulse never expires it
  localparam int unsigned OVL   = 800;
  localparam int unsigned BLANK = 10;

  logic clk;
  logic rst_b;
  logic clk_en;
  logic freq_shift_trip;
  logic hard_stop_trip;
  logic supply_on_reached;
  logic supply_below_off;
  logic css_above_low;
  logic css_above_start;
  logic burst_idle;
  logic osc_en;
  logic cycle_end;
  logic high_side_req;
  logic low_side_req;
  logic high_side_gate;
  logic low_side_gate;
  logic bootstrap_charge_en;
  logic css_discharge;
  logic soft_start_go;
  logic switching_on;
  logic fault_halt;
  int   error_cnt;
  int   n_tests;
  int   ce_cnt;

  rop_ocp_fsm #(.OVL_CYCLES(OVL), .BLANK_CYCLES(BLANK)) i_dut
  (
    .clk                (clk),
    .rst_b              (rst_b),
    .clk_en             (clk_en),
    .freq_shift_trip    (freq_shift_trip),
    .hard_stop_trip     (hard_stop_trip),
    .supply_on_reached  (supply_on_reached),
    .supply_below_off   (supply_below_off),
    .css_above_low      (css_above_low),
    .css_above_start    (css_above_start),
    .burst_idle         (burst_idle),
    .cycle_end          (cycle_end),
    .high_side_req      (high_side_req),
    .low_side_req       (low_side_req),
    .high_side_gate     (high_side_gate),
    .low_side_gate      (low_side_gate),
    .bootstrap_charge_en(bootstrap_charge_en),
    .css_discharge      (css_discharge),
    .soft_start_go      (soft_start_go),
    .switching_on       (switching_on),
    .fault_halt         (fault_halt)
  );

  rop_stage_model i_stage
  (
    .clk          (clk),
    .rst_b        (rst_b),
    .osc_en       (osc_en),
    .switching_on (switching_on),
    .cycle_end    (cycle_end),
    .high_side_req(high_side_req),
    .low_side_req (low_side_req)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (cycle_end === 1'b1)
      ce_cnt++;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic conclude();
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // 0 start pulse, 1 halted, 2 discharge closed
  task automatic wait_on(input int which, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      cyc(1);
      if ((which == 0 && soft_start_go === 1'b1) ||
          (which == 1 && fault_halt === 1'b1) ||
          (which == 2 && css_discharge === 1'b1))
        return;
    end
    error_cnt++;
    conclude();
  endtask

  task automatic restart();
    supply_on_reached = 1'b0;
    supply_below_off  = 1'b1;
    cyc(5);
    `CHK(fault_halt, 1'b0)
    supply_below_off  = 1'b0;
    supply_on_reached = 1'b1;
    wait_on(0, 10);
    `CHK(css_discharge, 1'b0)
    `CHK(switching_on, 1'b1)
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_blanking();
    freq_shift_trip = 1'b1;
    cyc(3);
    freq_shift_trip = 1'b0;
    cyc(15);
    `CHK(css_discharge, 1'b0)
    css_above_start = 1'b1;
    burst_idle      = 1'b1;
    cyc(5);
    burst_idle      = 1'b0;
    cyc(3);
    freq_shift_trip = 1'b1;
    cyc(3);
    freq_shift_trip = 1'b0;
    cyc(15);
    `CHK(css_discharge, 1'b0)
    cyc(BLANK + 5);
  endtask

  task automatic t_pulses();
    int n;
    for (int k = 0; k < 2; k++)
    begin
      freq_shift_trip = 1'b1;
      wait_on(2, 10);
      freq_shift_trip = 1'b0;
      // Second pulse is frozen in its first cycle; its length counts enabled cycles
      if (k == 1)
      begin
        clk_en = 1'b0;
        cyc(8);
        `CHK(css_discharge, 1'b1)
        clk_en = 1'b1;
      end
      n = 0;
      for (int i = 0; i < 2000 && css_discharge === 1'b1; i++)
      begin
        n++;
        cyc(1);
      end
      `CHK(n, rop_pkg::PULSE_CYCLES)
      cyc(5);
    end
    `CHK(fault_halt, 1'b0)
    `CHK(switching_on, 1'b1)
  endtask

  task automatic t_gates();
    logic seen_hi;
    logic seen_lo;
    seen_hi = 1'b0;
    seen_lo = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      `CHK(bootstrap_charge_en, low_side_gate)
      `CHK(high_side_gate & low_side_gate, 1'b0)
      seen_hi = seen_hi | high_side_gate;
      seen_lo = seen_lo | low_side_gate;
      cyc(1);
    end
    `CHK({seen_hi, seen_lo}, 2'h3)
  endtask

  task automatic t_hard();
    hard_stop_trip = 1'b1;
    cyc(30);
    `CHK(fault_halt, 1'b0)
    `CHK(switching_on, 1'b1)
    ce_cnt        = 0;
    css_above_low = 1'b1;
    wait_on(1, 40);
    `CHK(ce_cnt >= 1, 1'b1)
    `CHK({css_discharge, switching_on}, 2'h2)
    `CHK({high_side_gate, low_side_gate}, 2'h0)
    hard_stop_trip = 1'b0;
    css_above_low  = 1'b0;
    cyc(10);
    `CHK(fault_halt, 1'b1)
    restart();
  endtask

  task automatic t_gradual_shutdown();
    osc_en          = 1'b0;
    freq_shift_trip = 1'b1;
    cyc(OVL + 10);
    `CHK({css_discharge, switching_on}, 2'h3)
    `CHK(fault_halt, 1'b0)
    ce_cnt = 0;
    osc_en = 1'b1;
    wait_on(1, 2000);
    `CHK(ce_cnt, 128)
    freq_shift_trip = 1'b0;
    `CHK({high_side_gate, low_side_gate}, 2'h0)
    cyc(10);
    `CHK(fault_halt, 1'b1)
    restart();
  endtask

  initial
  begin
    error_cnt         = 0;
    n_tests           = 0;
    ce_cnt            = 0;
    rst_b             = 1'b0;
    clk_en            = 1'b1;
    freq_shift_trip   = 1'b0;
    hard_stop_trip    = 1'b0;
    supply_on_reached = 1'b0;
    supply_below_off  = 1'b0;
    css_above_low     = 1'b0;
    css_above_start   = 1'b0;
    burst_idle        = 1'b0;
    osc_en            = 1'b1;
    cyc(2);
    rst_b = 1'b1;
    cyc(3);
    `CHK({high_side_gate, low_side_gate}, 2'h0)
    `CHK(css_discharge, 1'b1)
    supply_on_reached = 1'b1;
    wait_on(0, 10);
    `CHK(css_discharge, 1'b0)
    t_blanking();
    t_pulses();
    t_gates();
    t_hard();
    t_gradual_shutdown();
    conclude();
  end
endmodule
